// >>> hdl/scl_serial_config.sv
// Serial port configuration: parameter store, reset-latched word format and
// baud generator, loop selection and special character recognition.
// Assumes received characters arrive from a character receiver on clk_in.
module scl_serial_config (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ctrl_reset_in,
  input wire logic [7:0] param_index_in,
  input wire logic [15:0] param_wdata_in,
  input wire logic param_write_in,
  input wire logic param_read_in,
  output logic [15:0] param_rdata_out,
  input wire logic [7:0] rx_char_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output logic [7:0] data_out,
  output logic data_valid_out,
  input wire logic data_ready_in,
  input wire logic service_request_in,
  output logic [7:0] tx_char_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output scl_pkg::scl_format_t word_format_out,
  output logic baud_tick_out,
  output logic loop_selected_out,
  output logic pause_out,
  output logic service_ack_out,
  output logic eof_seen_out
);
  import scl_pkg::*;

  scl_stream_if rx_s ();

  // --------------------------------------------------------------------------
  // Input buffer
  // --------------------------------------------------------------------------
  scl_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(rx_char_in),
    .wr_valid_in(rx_valid_in),
    .wr_ready_out(rx_ready_out),
    .rd(rx_s.source)
  );

  // --------------------------------------------------------------------------
  // Parameter store (what software last wrote)
  // --------------------------------------------------------------------------
  logic [15:0] gen_q, gen_d, clk_q, clk_d;
  logic [4:0] lcc_q, lcc_d, sreq_q, sreq_d, sack_q, sack_d, xon_q, xon_d, xoff_q, xoff_d;
  logic [7:0] addr_q, addr_d, eof_q, eof_d;
  logic len_q, len_d;
  logic [15:0] rdata_q, rdata_d;

  // Writes store the value cut to its field; the control, service and flow characters keep five bits only.
  always_comb
  begin
    gen_d = gen_q;
    clk_d = clk_q;
    lcc_d = lcc_q;
    addr_d = addr_q;
    len_d = len_q;
    eof_d = eof_q;
    sreq_d = sreq_q;
    sack_d = sack_q;
    xon_d = xon_q;
    xoff_d = xoff_q;
    if (param_write_in)
    begin
      unique case (param_index_in)
        IDX_GENERAL_CTRL: gen_d = param_wdata_in;
        IDX_CLOCK_CTRL: clk_d = param_wdata_in;
        IDX_LOOP_CTRL_CHAR: lcc_d = param_wdata_in[4:0];
        IDX_LOOP_ADDRESS: addr_d = param_wdata_in[7:0];
        IDX_LOOP_ENABLE: len_d = param_wdata_in[0];
        IDX_EOF_CHAR: eof_d = param_wdata_in[7:0];
        IDX_SERVICE_REQ_CHAR: sreq_d = param_wdata_in[4:0];
        IDX_SACK_CHAR: sack_d = param_wdata_in[4:0];
        IDX_XON_CHAR: xon_d = param_wdata_in[4:0];
        IDX_XOFF_CHAR: xoff_d = param_wdata_in[4:0];
        default: ;
      endcase
    end
    rdata_d = rdata_q;
    if (param_read_in)
    begin
      unique case (param_index_in)
        IDX_GENERAL_CTRL: rdata_d = gen_q;
        IDX_CLOCK_CTRL: rdata_d = clk_q;
        IDX_LOOP_CTRL_CHAR: rdata_d = {11'h000, lcc_q};
        IDX_LOOP_ADDRESS: rdata_d = {8'h00, addr_q};
        IDX_LOOP_ENABLE: rdata_d = {15'h0000, len_q};
        IDX_EOF_CHAR: rdata_d = {8'h00, eof_q};
        IDX_SERVICE_REQ_CHAR: rdata_d = {11'h000, sreq_q};
        IDX_SACK_CHAR: rdata_d = {11'h000, sack_q};
        IDX_XON_CHAR: rdata_d = {11'h000, xon_q};
        IDX_XOFF_CHAR: rdata_d = {11'h000, xoff_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      gen_q <= RST_GENERAL_CTRL;
      clk_q <= RST_CLOCK_CTRL;
      lcc_q <= RST_LOOP_CTRL_CHAR;
      addr_q <= RST_LOOP_ADDRESS;
      len_q <= RST_LOOP_ENABLE;
      eof_q <= RST_EOF_CHAR;
      sreq_q <= RST_SERVICE_REQ_CHAR;
      sack_q <= RST_SACK_CHAR;
      xon_q <= RST_XON_CHAR;
      xoff_q <= RST_XOFF_CHAR;
      rdata_q <= 16'h0000;
    end
    else
    begin
      gen_q <= gen_d;
      clk_q <= clk_d;
      lcc_q <= lcc_d;
      addr_q <= addr_d;
      len_q <= len_d;
      eof_q <= eof_d;
      sreq_q <= sreq_d;
      sack_q <= sack_d;
      xon_q <= xon_d;
      xoff_q <= xoff_d;
      rdata_q <= rdata_d;
    end
  end

  assign param_rdata_out = rdata_q;

  // --------------------------------------------------------------------------
  // Active configuration, taken over only on a controller reset
  // --------------------------------------------------------------------------
  scl_format_t fmt_q, fmt_d, fmt_dec;
  logic [11:0] div_q, div_d;
  logic pre_q, pre_d;
  logic [7:0] a_addr_q, a_addr_d;
  logic a_len_q, a_len_d;

  // Reserved codes fall back to the ten-bit format so the port always runs.
  always_comb
  begin
    unique case (gen_q[FMT_MSB:FMT_LSB])
      3'h0: fmt_dec = SCL_FMT_SYNC8;
      3'h2: fmt_dec = SCL_FMT_ASYNC10;
      3'h4: fmt_dec = SCL_FMT_PAR_EVEN;
      3'h5: fmt_dec = SCL_FMT_PAR_ODD;
      3'h6: fmt_dec = SCL_FMT_MULTIDROP;
      default: fmt_dec = SCL_FMT_ASYNC10;
    endcase
    fmt_d = ctrl_reset_in ? fmt_dec : fmt_q;
    div_d = ctrl_reset_in ? clk_q[DIV_MSB:DIV_LSB] : div_q;
    pre_d = ctrl_reset_in ? clk_q[PRESCALE_BIT] : pre_q;
    a_addr_d = ctrl_reset_in ? addr_q : a_addr_q;
    a_len_d = ctrl_reset_in ? len_q : a_len_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      fmt_q <= SCL_FMT_ASYNC10;
      div_q <= RST_CLOCK_CTRL[DIV_MSB:DIV_LSB];
      pre_q <= RST_CLOCK_CTRL[PRESCALE_BIT];
      a_addr_q <= RST_LOOP_ADDRESS;
      a_len_q <= RST_LOOP_ENABLE;
    end
    else
    begin
      fmt_q <= fmt_d;
      div_q <= div_d;
      pre_q <= pre_d;
      a_addr_q <= a_addr_d;
      a_len_q <= a_len_d;
    end
  end

  assign word_format_out = fmt_q;

  // --------------------------------------------------------------------------
  // Baud generator
  // --------------------------------------------------------------------------
  logic [26:0] acc_q, acc_d;
  logic [11:0] bcnt_q, bcnt_d;
  logic [2:0] pcnt_q, pcnt_d;
  logic tick_q, tick_d, ref_tick, div_tick;

  // The accumulator keeps the 320 kHz reference exact on average even though
  // 125 MHz is not an integer multiple; single ticks jitter by one cycle.
  always_comb
  begin
    ref_tick = (acc_q + ACC_STEP) >= ACC_MOD;
    acc_d = ref_tick ? acc_q + ACC_STEP - ACC_MOD : acc_q + ACC_STEP;
    div_tick = ref_tick && (bcnt_q == div_q);
    bcnt_d = bcnt_q;
    if (ref_tick)
    begin
      bcnt_d = div_tick ? 12'h000 : bcnt_q + 12'h001;
    end
    pcnt_d = pcnt_q;
    if (div_tick && pre_q)
    begin
      pcnt_d = pcnt_q + 3'h1;
    end
    tick_d = div_tick && (!pre_q || (pcnt_q == PRESCALE_LAST));
    // Restarting the reference too keeps the first new tick a full bit away.
    if (ctrl_reset_in)
    begin
      acc_d = 27'h0000000;
      bcnt_d = 12'h000;
      pcnt_d = 3'h0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      acc_q <= 27'h0000000;
      bcnt_q <= 12'h000;
      pcnt_q <= 3'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      bcnt_q <= bcnt_d;
      pcnt_q <= pcnt_d;
      tick_q <= tick_d;
    end
  end

  assign baud_tick_out = tick_q;

  // --------------------------------------------------------------------------
  // Received character decoding and loop selection
  // --------------------------------------------------------------------------
  scl_state_t st_q, st_d;
  logic sel_q, sel_d, pause_q, pause_d, ack_q, ack_d, eof_sq, eof_sd;
  logic [7:0] dout_q, dout_d;
  logic dval_q, dval_d, take, active;
  logic [7:0] ch;

  // A character is taken only when the output slot is free, so a stalled
  // consumer backs up into the buffer and then onto rx_ready_out.
  always_comb
  begin
    ch = rx_s.data;
    active = !a_len_q || sel_q;
    take = rx_s.valid && (!dval_q || data_ready_in);
    rx_s.ready = take;
    st_d = st_q;
    sel_d = sel_q;
    pause_d = pause_q;
    ack_d = 1'b0;
    eof_sd = 1'b0;
    dout_d = dout_q;
    dval_d = dval_q && !data_ready_in;
    if (take)
    begin
      unique case (st_q)
        SCL_ST_DATA:
        begin
          if (a_len_q && ch == {3'h0, lcc_q})
          begin
            st_d = SCL_ST_ADDR;
          end
          else if (active && ch == {3'h0, xoff_q})
          begin
            pause_d = 1'b1;
          end
          else if (active && ch == {3'h0, xon_q})
          begin
            pause_d = 1'b0;
          end
          else if (active && ch == {3'h0, sack_q})
          begin
            ack_d = 1'b1;
          end
          else if (active)
          begin
            eof_sd = (ch == eof_q);
            dout_d = ch;
            dval_d = 1'b1;
          end
        end
        SCL_ST_ADDR:
        begin
          st_d = SCL_ST_DATA;
          sel_d = (ch != CLOSE_LOOP_CHAR) && (ch == a_addr_q);
        end
      endcase
    end
    if (ctrl_reset_in)
    begin
      st_d = SCL_ST_DATA;
      sel_d = 1'b0;
      pause_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_q <= SCL_ST_DATA;
      sel_q <= 1'b0;
      pause_q <= 1'b0;
      ack_q <= 1'b0;
      eof_sq <= 1'b0;
      dout_q <= 8'h00;
      dval_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      sel_q <= sel_d;
      pause_q <= pause_d;
      ack_q <= ack_d;
      eof_sq <= eof_sd;
      dout_q <= dout_d;
      dval_q <= dval_d;
    end
  end

  assign loop_selected_out = active;
  assign pause_out = pause_q;
  assign service_ack_out = ack_q;
  assign eof_seen_out = eof_sq;
  assign data_out = dout_q;
  assign data_valid_out = dval_q;

  // --------------------------------------------------------------------------
  // Service request transmission
  // --------------------------------------------------------------------------
  logic [7:0] tx_q, tx_d;
  logic txv_q, txv_d;

  // A request while one is pending and not taken that cycle is merged: the host sees a single request.
  always_comb
  begin
    tx_d = tx_q;
    txv_d = txv_q && !tx_ready_in;
    if (service_request_in && !txv_d)
    begin
      tx_d = {3'h0, sreq_q};
      txv_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      tx_q <= 8'h00;
      txv_q <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
      txv_q <= txv_d;
    end
  end

  assign tx_char_out = tx_q;
  assign tx_valid_out = txv_q;
endmodule : scl_serial_config

// >>> shared/scl_pkg.sv
// Constants, field layouts and types for the serial port configuration block.
// Assumes a 125 MHz system clock and parameter access by numeric index.
// Overview of operation
// - Low three control bits select word format.
// - General control comes up as 0x302.
// - New settings act only after controller reset; here only format, divider, prescaler, loop address and loop enable wait for it.
// - Divider low twelve bits, bit 13 prescales.
// - Clock control defaults 0x20, 9600 bits/second.
// - Prescaler set gives 1200, 600, 300 rates.
// - Loop control character opens or closes participation.
// - Character after control character is address.
// - Loop control character limited to 0..0x1f.
// - Configurable resume and pause flow characters.
// - Send service request, host acknowledges it.
// - Configurable end-of-file character marks file end.
// - Unique address 0x41..0x5a; space deselects all.
// - Loop addressing only when loop enable is 1.
package scl_pkg;
  // --------------------------------------------------------------------------
  // Parameter indexes
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_GENERAL_CTRL = 8'h01;
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'h02;
  localparam logic [7:0] IDX_LOOP_CTRL_CHAR = 8'h03;
  localparam logic [7:0] IDX_LOOP_ADDRESS = 8'h04;
  localparam logic [7:0] IDX_LOOP_ENABLE = 8'h05;
  localparam logic [7:0] IDX_EOF_CHAR = 8'h1b;
  localparam logic [7:0] IDX_SERVICE_REQ_CHAR = 8'h1c;
  localparam logic [7:0] IDX_SACK_CHAR = 8'h1d;
  localparam logic [7:0] IDX_XON_CHAR = 8'h20;
  localparam logic [7:0] IDX_XOFF_CHAR = 8'h21;
  // --------------------------------------------------------------------------
  // Reset values and field layout
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_GENERAL_CTRL = 16'h0302;
  localparam logic [15:0] RST_CLOCK_CTRL = 16'h0020;
  localparam logic [4:0] RST_LOOP_CTRL_CHAR = 5'h03;
  localparam logic [7:0] RST_LOOP_ADDRESS = 8'h41;
  localparam logic RST_LOOP_ENABLE = 1'b0;
  localparam logic [7:0] RST_EOF_CHAR = 8'h7e;
  localparam logic [4:0] RST_SERVICE_REQ_CHAR = 5'h16;
  localparam logic [4:0] RST_SACK_CHAR = 5'h17;
  localparam logic [4:0] RST_XON_CHAR = 5'h1c;
  localparam logic [4:0] RST_XOFF_CHAR = 5'h1d;
  localparam logic [7:0] CLOSE_LOOP_CHAR = 8'h20;
  localparam int FMT_LSB = 0;
  localparam int FMT_MSB = 2;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 11;
  localparam int PRESCALE_BIT = 13;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  // --------------------------------------------------------------------------
  // Timing: 320 kHz reference made from the system clock by a phase accumulator
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 125000000;
  localparam int REF_HZ = 320000;
  localparam logic [26:0] ACC_MOD = 27'(CLK_HZ);
  localparam logic [26:0] ACC_STEP = 27'(REF_HZ);
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SCL_FMT_SYNC8 = 3'h0,
    SCL_FMT_ASYNC10 = 3'h2,
    SCL_FMT_PAR_EVEN = 3'h4,
    SCL_FMT_PAR_ODD = 3'h5,
    SCL_FMT_MULTIDROP = 3'h6
  } scl_format_t;
  typedef enum logic [1:0] {
    SCL_ST_DATA = 2'h0,
    SCL_ST_ADDR = 2'h1
  } scl_state_t;
endpackage : scl_pkg

// >>> shared/scl_stream_if.sv
// Valid/ready character stream between the buffer and the decoder.
// Assumes both ends run on the same clock.
interface scl_stream_if;
  logic [7:0] data;
  logic valid;
  logic ready;
  modport source (output data, output valid, input ready);
  modport sink (input data, input valid, output ready);
endinterface : scl_stream_if

// >>> hdl/scl_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module scl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  scl_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0] count_q, count_d;
  logic push, pop;

  // Pointer and count bookkeeping; full and empty come straight from the count.
  always_comb
  begin
    push = wr_valid_in && (count_q != (AW+1)'(DEPTH));
    pop = (count_q != '0) && rd.ready;
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // Storage holds no reset; only counted entries are ever read.
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= wr_data_in;
    end
  end

  assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data = mem_q[rd_ptr_q];
endmodule : scl_fifo

// >>> verification/scl_serial_config_props.sv
// Port-level checks for the serial port configuration block.
// Assumes one clock domain with a synchronous active-low reset.
module scl_serial_config_props
  import scl_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ctrl_reset_in,
  input wire logic param_read_in,
  input wire logic [15:0] param_rdata_out,
  input wire logic [7:0] data_out,
  input wire logic data_valid_out,
  input wire logic data_ready_in,
  input wire logic service_request_in,
  input wire logic [7:0] tx_char_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire scl_pkg::scl_format_t word_format_out,
  input wire logic baud_tick_out,
  input wire logic eof_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // The active format may move only on the edge of a controller reset.
  a_fmt_held_between: assert property (
    $past(resetn_in) && !$past(ctrl_reset_in) |-> $stable(word_format_out))
    else $error("format changed without controller reset");
  a_fmt_code_legal: assert property (
    word_format_out inside {SCL_FMT_SYNC8, SCL_FMT_ASYNC10, SCL_FMT_PAR_EVEN,
      SCL_FMT_PAR_ODD, SCL_FMT_MULTIDROP})
    else $error("reserved format code active");
  // The fastest rate is far below the clock, so ticks are isolated.
  a_tick_isolated: assert property (baud_tick_out |=> !baud_tick_out [*8])
    else $error("baud ticks too close");
  a_tick_restart: assert property (ctrl_reset_in |=> !baud_tick_out [*8])
    else $error("baud tick right after controller reset");
  a_data_held: assert property (
    data_valid_out && !data_ready_in && !ctrl_reset_in |=> data_valid_out && $stable(data_out))
    else $error("received data dropped while stalled");
  a_eof_with_data: assert property (eof_seen_out |-> data_valid_out)
    else $error("end of file flag without data");
  a_tx_held: assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
    else $error("service request dropped while stalled");
  a_tx_answer: assert property (
    service_request_in && !tx_valid_out && !ctrl_reset_in |=> tx_valid_out)
    else $error("service request not sent");
  a_rdata_stands: assert property (!$past(param_read_in) |-> $stable(param_rdata_out))
    else $error("read data changed without a read");
endmodule : scl_serial_config_props

bind scl_serial_config scl_serial_config_props u_props (.clk_in(clk_in),
  .resetn_in(resetn_in), .ctrl_reset_in(ctrl_reset_in), .param_read_in(param_read_in),
  .param_rdata_out(param_rdata_out), .data_out(data_out), .data_valid_out(data_valid_out),
  .data_ready_in(data_ready_in), .service_request_in(service_request_in),
  .tx_char_out(tx_char_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .word_format_out(word_format_out), .baud_tick_out(baud_tick_out),
  .eof_seen_out(eof_seen_out));

// >>> verification/scl_host_model.sv
// Behavioural host on the far side of the serial character streams.
// Assumes the bench queues characters in q; runs on the block's clock.
module scl_host_model #(
  parameter logic [7:0] SREQ_CHAR = 8'h16,
  parameter logic [7:0] SACK_CHAR = 8'h17
) (
  input wire logic clk_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_char_out,
  output logic rx_valid_out,
  input wire logic [7:0] tx_char_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic slow_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q [$];
  logic [7:0] last_tx = 8'h00;
  int n_tx = 0;
  initial
  begin
    rx_char_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // A character stands until taken; an idle line shows the inverse to expose stale use.
  always @(posedge clk_in)
  begin
    if (rx_valid_out && rx_ready_in)
      void'(q.pop_front());
    rx_valid_out <= (q.size() > 0);
    rx_char_out <= (q.size() > 0) ? q[0] : ~rx_char_out;
    if (tx_valid_in && tx_ready_out)
    begin
      last_tx <= tx_char_in;
      n_tx <= n_tx + 1;
      if (tx_char_in == SREQ_CHAR)
        q.push_back(SACK_CHAR);
    end
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  end
endmodule : scl_host_model

// >>> verification/scl_serial_config_tb.sv
// Self-checking bench for the serial port configuration block.
// Assumes the host model on the character streams and the bound checker.
module scl_serial_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scl_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, ctrl_reset_in = 1'b0, slow = 1'b0, drain = 1'b0;
  logic param_write_in = 1'b0, param_read_in = 1'b0, data_ready_in = 1'b1;
  logic service_request_in = 1'b0;
  logic [7:0] param_index_in = 8'h00;
  logic [15:0] param_wdata_in = 16'h0000, param_rdata_out, fmt = 16'h0002;
  logic [7:0] rx_char, data_out, tx_char;
  logic rx_valid, rx_ready_out, data_valid_out, tx_valid, tx_ready, baud_tick_out;
  logic loop_selected_out, pause_out, service_ack_out, eof_seen_out;
  scl_format_t word_format_out;
  int n_fail = 0, num_checks = 0, cyc = 0, n_ack = 0, n_eof = 0, i, t0;
  int prm [0:7];
  logic [7:0] exp_q [$];
  logic [31:0] rng = 32'h12, r;
  logic [15:0] bt [4] = '{16'h0020, 16'h0000, 16'h1005, 16'h2000};

  scl_serial_config u_scl_serial_config (.clk_in(clk_in), .resetn_in(resetn_in),
    .ctrl_reset_in(ctrl_reset_in), .param_index_in(param_index_in),
    .param_wdata_in(param_wdata_in), .param_write_in(param_write_in),
    .param_read_in(param_read_in), .param_rdata_out(param_rdata_out),
    .rx_char_in(rx_char), .rx_valid_in(rx_valid), .rx_ready_out(rx_ready_out),
    .data_out(data_out), .data_valid_out(data_valid_out), .data_ready_in(data_ready_in),
    .service_request_in(service_request_in), .tx_char_out(tx_char),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .word_format_out(word_format_out),
    .baud_tick_out(baud_tick_out), .loop_selected_out(loop_selected_out),
    .pause_out(pause_out), .service_ack_out(service_ack_out), .eof_seen_out(eof_seen_out));
  scl_host_model u_scl_host_model (.clk_in(clk_in), .rx_ready_in(rx_ready_out),
    .rx_char_out(rx_char), .rx_valid_out(rx_valid), .tx_char_in(tx_char),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .slow_in(slow));

  // ------------------------------------------------------------
  // Clock, helpers and tasks
  // ------------------------------------------------------------
  always #4 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task wr(input int idx, input logic [15:0] v);
    @(posedge clk_in);
    param_index_in <= 8'(idx);
    param_wdata_in <= v;
    param_write_in <= 1'b1;
    @(posedge clk_in);
    param_write_in <= 1'b0;
    if (idx < 3)
      prm[idx] = int'(v);
    if (idx == 3)
      prm[3] = int'(v & 16'h001f);
  endtask : wr
  task rd(input int idx);
    @(posedge clk_in);
    param_index_in <= 8'(idx);
    param_read_in <= 1'b1;
    @(posedge clk_in);
    param_read_in <= 1'b0;
    @(posedge clk_in);
    #1 check(param_rdata_out, 16'(prm[idx]), "parameter");
  endtask : rd
  task creset;
    @(posedge clk_in);
    ctrl_reset_in <= 1'b1;
    @(posedge clk_in);
    ctrl_reset_in <= 1'b0;
  endtask : creset
  task send(input logic [7:0] c, input bit fwd);
    u_scl_host_model.q.push_back(c);
    if (fwd)
      exp_q.push_back(c);
  endtask : send
  // Waits until every queued character has been taken and delivered.
  task settle;
    for (int k = 0; k < 400 && (u_scl_host_model.q.size() + exp_q.size()) > 0; k++)
      @(posedge clk_in);
    repeat (4) @(posedge clk_in);
  endtask : settle
  // Tick spacing is averaged over the 390.625-cycle reference, so allow one and a half cycles of jitter.
  task measure(input logic [15:0] v);
    int e, d;
    wr(2, v);
    creset;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_in);
      for (int t = 0; t < 30000 && baud_tick_out !== 1'b1; t++)
        @(posedge clk_in);
      if (k == 0)
        t0 = cyc;
    end
    e = (int'(v[11:0]) + 1) * (v[13] ? 8 : 1) * 390625;
    d = (cyc - t0) * 1000 - e;
    check(16'(d > -1500 && d < 1500), 16'h1, "baud");
  endtask : measure

  // ------------------------------------------------------------
  // Reference comparison of delivered data and event counts
  // ------------------------------------------------------------
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (data_valid_out === 1'b1 && data_ready_in === 1'b1)
      check(16'(data_out), exp_q.size() ? 16'(exp_q.pop_front()) : 16'h01ff, "data");
    if (service_ack_out === 1'b1)
      n_ack++;
    if (eof_seen_out === 1'b1)
      n_eof++;
    rng = xs(rng);
    if (drain)
      data_ready_in <= rng[0];
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial
  begin
    prm = '{0, 32'h302, 32'h20, 32'h3, 0, 0, 0, 0};
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    #1 check({13'h0, word_format_out}, 16'h0002, "format");
    check(16'(loop_selected_out), 16'h1, "selected");
    rd(1);
    rd(2);
    rd(3);
    wr(7, 16'h1234);
    rd(7);
    // Fill the buffer while the consumer stalls, then drain at random.
    data_ready_in <= 1'b0;
    for (i = 0; i < 10; i++)
    begin
      r = xs(rng ^ 32'(i));
      send(8'h30 + {2'h0, r[5:0]}, 1'b1);
    end
    repeat (40) @(posedge clk_in);
    check(16'(rx_ready_out), 16'h0, "rx_ready");
    drain <= 1'b1;
    settle;
    drain <= 1'b0;
    @(posedge clk_in);
    data_ready_in <= 1'b1;
    // Every format code; reserved codes fall back to ten-bit framing.
    for (i = 0; i < 8; i++)
    begin
      wr(1, 16'h0300 + 16'(i));
      rd(1);
      check({13'h0, word_format_out}, fmt, "format held");
      creset;
      fmt = (i inside {0, 2, 4, 5, 6}) ? 16'(i) : 16'h0002;
      #1 check({13'h0, word_format_out}, fmt, "format");
    end
    for (i = 0; i < 4; i++)
      measure(bt[i]);
    wr(3, 16'h003f);
    rd(3);
    wr(4, 16'h0043);
    wr(5, 16'h0001);
    creset;
    #1 check(16'(loop_selected_out), 16'h0, "selected");
    send(8'h55, 1'b0);
    send(8'h1f, 1'b0);
    send(8'h43, 1'b0);
    send(8'h3a, 1'b1);
    settle;
    check(16'(loop_selected_out), 16'h1, "selected");
    send(8'h1f, 1'b0);
    send(8'h41, 1'b0);
    send(8'h3b, 1'b0);
    settle;
    check(16'(loop_selected_out), 16'h0, "selected");
    send(8'h1f, 1'b0);
    send(8'h43, 1'b0);
    send(8'h1d, 1'b0);
    settle;
    check(16'(pause_out), 16'h1, "pause");
    send(8'h1c, 1'b0);
    send(8'h7e, 1'b1);
    settle;
    check(16'(pause_out), 16'h0, "pause");
    check(16'(n_eof), 16'h1, "eof");
    // Service request while the host takes it slowly.
    slow <= 1'b1;
    @(posedge clk_in);
    service_request_in <= 1'b1;
    @(posedge clk_in);
    service_request_in <= 1'b0;
    for (i = 0; i < 100 && u_scl_host_model.n_tx == 0; i++)
      @(posedge clk_in);
    settle;
    check(16'(u_scl_host_model.last_tx), 16'h0016, "request");
    check(16'(n_ack), 16'h1, "ack");
    send(8'h1f, 1'b0);
    send(8'h20, 1'b0);
    settle;
    check(16'(loop_selected_out), 16'h0, "selected");
    final_report;
  end
  // Watchdog sized well above the longest baud measurements.
  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    final_report;
  end
endmodule : scl_serial_config_tb
